// file: hdl/itc_top.sv
// Trigger, illumination and switching output sequencer of the camera.
// Assumes software on a one-cycle strobe register port, pin trigger async.
`timescale 1ns/1ps
`default_nettype none
module itc_top
  import itc_pkg::*;
#(
  parameter int unsigned DEB_CYCLES  = DEB_CYC,
  parameter int unsigned LEAD_CYCLES = LEAD_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata,
  input  wire logic        trigger_in,
  input  wire logic        capture_done_in,
  output var  logic        switched_output_line,
  output var  logic        light_on,
  output var  logic [3:0]  led_on,
  output var  logic [1:0]  led_colour,
  output var  logic        expose,
  output var  logic [2:0]  active_set
);
  logic [31:0] ctrl;
  logic [31:0] delay_cfg;
  logic [31:0] period_cfg;
  logic [2:0]  set_sel;
  logic [31:0] set_val [NUM_SETS];
  logic [7:0]  light_cfg;
  logic [2:0]  out_src;
  logic        iface_lvl;
  logic        user_lvl;
  logic        ovr_flag;
  logic        err_flag;
  logic [15:0] ovr_cnt;
  logic [31:0] cnt;
  logic [31:0] rate_cnt;
  logic        trg_prev;
  logic        cap_cmd;
  itc_state_t  state;
  itc_state_t  next_state;
  logic [2:0]  cur_set;

  logic trg_sync;
  logic trg_lvl;
  itc_sync u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (trigger_in),
    .dout (trg_sync)
  );
  itc_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
    .clk    (clk),
    .rst    (rst),
    .enable (ctrl[CTRL_DEB_BIT]),
    .din    (trg_sync),
    .dout   (trg_lvl)
  );

  logic done_sync;
  // External status is asynchronous too, so it gets the same synchroniser, but no debounce filter
  itc_sync u_done_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (capture_done_in),
    .dout (done_sync)
  );

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  wire [2:0] mode     = ctrl[CTRL_MODE_LSB +: 3];
  wire       int_mode = ctrl[CTRL_INT_BIT];
  wire       rise     = trg_lvl && !trg_prev;
  wire       fall     = !trg_lvl && trg_prev;
  // R1
  wire       pin_evt  = !int_mode && (
                   (mode == ITC_TM_FALL  && fall) ||
                   (mode == ITC_TM_RISE  && rise) ||
                   (mode == ITC_TM_BOTH  && (rise || fall)) ||
                   (mode == ITC_TM_GATED && rise) ||
                   (mode == ITC_TM_BURST && rise));
  // Gated and burst keep capturing while the level holds
  wire       hold_lvl = !int_mode && trg_lvl &&
                   (mode == ITC_TM_GATED || mode == ITC_TM_BURST);
  wire       rate_hit = int_mode && (rate_cnt == 32'h0000_0000); // R9
  wire       cmd_evt  = !int_mode && cap_cmd; // R10
  wire       req      = pin_evt || cmd_evt || rate_hit ||
                        (hold_lvl && state == ITC_ST_READY);
  wire       is_ready = (state == ITC_ST_READY);
  wire       accept   = req && is_ready; // R15
  wire       overrun  = (pin_evt || cmd_evt) && !is_ready; // R3
  wire       cnt_zero = (cnt == 32'h0000_0000);
  wire       wr_cmd   = wr && hit(addr, REG_CMD);
  wire       ovr_clr  = wr_cmd && wdata[CMD_OVC_BIT];
  wire       err_clr  = wr_cmd && wdata[CMD_ERC_BIT];
  wire       err_set  = overrun || (wr_cmd && wdata[CMD_IERR_BIT]);
  wire       sel_ok   = (set_sel < 3'(NUM_SETS));
  wire [31:0] exp_len = set_val[cur_set];

  always_comb begin
    next_state = state;
    case (state)
      ITC_ST_READY:  if (accept) next_state = ITC_ST_DELAY; // R2
      ITC_ST_DELAY:  if (cnt_zero) next_state = ITC_ST_LEAD; // R7
      ITC_ST_LEAD:   if (cnt_zero) next_state = ITC_ST_EXPOSE; // R12
      ITC_ST_EXPOSE: if (cnt_zero) next_state = ITC_ST_DONE;
      ITC_ST_DONE:   next_state = ITC_ST_READY; // R17
      default:       next_state = ITC_ST_READY;
    endcase
  end

  wire [31:0] next_cnt =
      (state == ITC_ST_READY && accept) ? delay_cfg :
      (state == ITC_ST_DELAY && cnt_zero) ? 32'(LEAD_CYCLES - 1) :
      (state == ITC_ST_LEAD && cnt_zero) ? exp_len - 32'h0000_0001 :
      cnt_zero ? cnt : cnt - 32'h0000_0001;

  // R14
  wire src_lvl =
      (out_src == ITC_SRC_READY) ? (is_ready && !int_mode) : // R4 R16
      (out_src == ITC_SRC_DONE)  ? (state == ITC_ST_DONE) :
      (out_src == ITC_SRC_ERROR) ? err_flag : // R18
      (out_src == ITC_SRC_IFACE) ? iface_lvl : // R19
      (out_src == ITC_SRC_USER)  ? user_lvl : 1'b0; // R13
  wire lamp = (state == ITC_ST_LEAD) || (state == ITC_ST_EXPOSE); // R11

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ITC_ST_READY;
      cnt   <= 32'h0000_0000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rate_cnt <= 32'h0000_0000;
      trg_prev <= 1'b0;
      cur_set  <= 3'h0;
    end else begin
      trg_prev <= trg_lvl;
      rate_cnt <= (rate_hit || !int_mode) ? period_cfg : rate_cnt - 32'h1;
      if (accept) begin
        cur_set <= sel_ok ? set_sel : 3'h0; // R8
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl       <= CTRL_RST;
      delay_cfg  <= DELAY_RST;
      period_cfg <= PERIOD_RST;
      set_sel    <= 3'h0;
      light_cfg  <= 8'h00;
      out_src    <= ITC_SRC_NONE;
    end else if (wr) begin
      if (hit(addr, REG_CTRL))   ctrl <= wdata;
      if (hit(addr, REG_DELAY))  delay_cfg <= wdata;
      if (hit(addr, REG_PERIOD)) period_cfg <= wdata;
      if (hit(addr, REG_SETSEL)) set_sel <= wdata[2:0];
      if (hit(addr, REG_LIGHT))  light_cfg <= wdata[7:0];
      if (hit(addr, REG_OUTCFG)) out_src <= wdata[2:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SETS; gi++) begin : g_set
      always_ff @(posedge clk) begin
        if (rst) begin
          set_val[gi] <= SETV_RST;
        end else if (wr && hit(addr, REG_SETVAL) && set_sel == 3'(gi)) begin
          set_val[gi] <= (wdata == 32'h0000_0000) ? 32'h0000_0001 : wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      cap_cmd   <= 1'b0;
      iface_lvl <= 1'b0;
      user_lvl  <= 1'b0;
      ovr_flag  <= 1'b0;
      err_flag  <= 1'b0;
      ovr_cnt   <= 16'h0000;
    end else begin
      cap_cmd <= wr_cmd && wdata[CMD_CAP_BIT];
      if (wr_cmd) begin
        iface_lvl <= wdata[CMD_LVL_BIT];
        user_lvl  <= wdata[CMD_USR_BIT];
      end
      // Set beats clear when both land together
      if (overrun) ovr_flag <= 1'b1; // R23
      else if (ovr_clr) ovr_flag <= 1'b0;
      if (err_set) err_flag <= 1'b1;
      else if (err_clr) err_flag <= 1'b0;
      if (overrun && ovr_cnt != 16'hFFFF) ovr_cnt <= ovr_cnt + 16'h0001;
      else if (ovr_clr) ovr_cnt <= 16'h0000;
    end
  end

  wire [31:0] status_w = {24'h00_0000, 1'b0, done_sync, err_flag,
                          ovr_flag, 1'b0, 3'(state)};
  wire [31:0] rd_mux =
      hit(addr, REG_CTRL)    ? ctrl :
      hit(addr, REG_DELAY)   ? delay_cfg :
      hit(addr, REG_PERIOD)  ? period_cfg :
      hit(addr, REG_SETSEL)  ? {29'h0000_0000, set_sel} :
      hit(addr, REG_SETVAL)  ? (sel_ok ? set_val[set_sel] : 32'h0) :
      hit(addr, REG_LIGHT)   ? {24'h00_0000, light_cfg} :
      hit(addr, REG_OUTCFG)  ? {29'h0000_0000, out_src} :
      hit(addr, REG_STATUS)  ? status_w :
      hit(addr, REG_ERRINFO) ? {16'h0000, ovr_cnt} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata                <= 32'h0000_0000;
      switched_output_line <= 1'b0;
      light_on             <= 1'b0;
      led_on               <= 4'h0;
      led_colour           <= 2'h0;
      expose               <= 1'b0;
      active_set           <= 3'h0;
    end else begin
      rdata                <= rd ? rd_mux : 32'h0000_0000;
      switched_output_line <= src_lvl;
      light_on             <= lamp;
      led_on               <= lamp ? light_cfg[3:0] : 4'h0; // R20
      led_colour           <= light_cfg[5:4]; // R21
      expose               <= (state == ITC_ST_EXPOSE);
      active_set           <= cur_set;
    end
  end

  // Trigger acceptance and refusal
  busy_no_start_a: assert property (@(posedge clk) disable iff (rst) // R2
    state != ITC_ST_READY && !$past(rst) |=> state != ITC_ST_DELAY ||
    $past(state) == ITC_ST_DELAY)
    else $error("Trigger started while busy");
  ready_only_a: assert property (@(posedge clk) disable iff (rst) // R15
    state == ITC_ST_DELAY |->
    $past(state) == ITC_ST_READY || $past(state) == ITC_ST_DELAY)
    else $error("Capture started outside ready state");
  edge_start_a: assert property (@(posedge clk) disable iff (rst) // R1
    pin_evt && is_ready |=> state == ITC_ST_DELAY)
    else $error("Pin edge in ready state not taken");
  level_repeat_a: assert property (@(posedge clk) disable iff (rst) // R1
    hold_lvl && is_ready |=> state == ITC_ST_DELAY)
    else $error("Held level did not repeat capture");
  cmd_start_a: assert property (@(posedge clk) disable iff (rst) // R10
    cmd_evt && is_ready |=> state == ITC_ST_DELAY)
    else $error("Capture command in ready state not taken");
  rate_start_a: assert property (@(posedge clk) disable iff (rst) // R9
    rate_hit && is_ready |=> state == ITC_ST_DELAY)
    else $error("Frame period elapsed without capture");
  overrun_flag_a: assert property (@(posedge clk) disable iff (rst) // R3
    overrun |=> ovr_flag)
    else $error("Overrun not flagged");
  overrun_drop_a: assert property (@(posedge clk) disable iff (rst) // R3
    overrun |=> state != ITC_ST_DELAY || $past(state) == ITC_ST_DELAY)
    else $error("Overrun trigger started a capture");
  overrun_count_a: assert property (@(posedge clk) disable iff (rst) // R3
    overrun && ovr_cnt != 16'hFFFF |=> ovr_cnt == $past(ovr_cnt) + 16'h0001)
    else $error("Overrun not counted");
  sticky_ovr_a: assert property (@(posedge clk) disable iff (rst) // R23
    ovr_flag && !ovr_clr |=> ovr_flag)
    else $error("Overrun flag dropped without clear");
  set_range_a: assert property (@(posedge clk) disable iff (rst) // R8
    cur_set < 3'(NUM_SETS))
    else $error("Parameter set index out of range");

  // Sequence timing and lighting
  delay_load_a: assert property (@(posedge clk) disable iff (rst) // R7
    accept |=> state == ITC_ST_DELAY && cnt == $past(delay_cfg))
    else $error("Trigger delay not loaded");
  lead_time_a: assert property (@(posedge clk) disable iff (rst) // R12
    $rose(state == ITC_ST_LEAD) |->
    (state == ITC_ST_LEAD)[*2] ##0 !expose)
    else $error("Exposure began before lighting lead");
  lead_light_a: assert property (@(posedge clk) disable iff (rst) // R12
    $rose(expose) |-> $past(light_on) && $past(light_on, 2))
    else $error("Exposure began without lighting lead");
  light_follow_a: assert property (@(posedge clk) disable iff (rst) // R11
    state == ITC_ST_EXPOSE |=> light_on)
    else $error("Light off during exposure");
  lamp_off_a: assert property (@(posedge clk) disable iff (rst) // R11
    state == ITC_ST_READY |=> !light_on)
    else $error("Light on while idle");
  led_gate_a: assert property (@(posedge clk) disable iff (rst) // R20
    !light_on |-> led_on == 4'h0)
    else $error("LED enabled while light off");
  led_enable_a: assert property (@(posedge clk) disable iff (rst) // R20
    light_on |-> led_on == $past(light_cfg[3:0]))
    else $error("LED enables not applied");
  colour_one_a: assert property (@(posedge clk) disable iff (rst) // R21
    led_colour == $past(light_cfg[5:4]))
    else $error("Colour not applied to all LEDs");
  done_pulse_a: assert property (@(posedge clk) disable iff (rst) // R17
    state == ITC_ST_DONE |=> state == ITC_ST_READY)
    else $error("Done state not one cycle");

  // Switching output sources
  out_idle_a: assert property (@(posedge clk) disable iff (rst) // R13
    out_src == ITC_SRC_NONE |=> !switched_output_line)
    else $error("Output driven without a source");
  ready_out_a: assert property (@(posedge clk) disable iff (rst) // R4
    out_src == ITC_SRC_READY && $stable(out_src) |=>
    switched_output_line == ($past(is_ready) && !$past(int_mode)))
    else $error("Output does not show ready state");
  ready_hidden_a: assert property (@(posedge clk) disable iff (rst) // R16
    int_mode && out_src == ITC_SRC_READY && $stable(int_mode) |=>
    !switched_output_line)
    else $error("Ready shown in continuous mode");
  done_out_a: assert property (@(posedge clk) disable iff (rst) // R17
    out_src == ITC_SRC_DONE && $stable(out_src) |=>
    switched_output_line == ($past(state) == ITC_ST_DONE))
    else $error("Output does not show capture finished");
  err_out_a: assert property (@(posedge clk) disable iff (rst) // R18
    out_src == ITC_SRC_ERROR && $stable(out_src) |=>
    switched_output_line == $past(err_flag))
    else $error("Output does not show internal error");
  err_sticky_a: assert property (@(posedge clk) disable iff (rst) // R18
    err_flag && !err_clr |=> err_flag)
    else $error("Error flag dropped without clear");
  iface_level_a: assert property (@(posedge clk) disable iff (rst) // R19
    out_src == ITC_SRC_IFACE && $stable(out_src) |=>
    switched_output_line == $past(iface_lvl))
    else $error("Output does not follow command level");
  user_level_a: assert property (@(posedge clk) disable iff (rst) // R14
    out_src == ITC_SRC_USER && $stable(out_src) |=>
    switched_output_line == $past(user_lvl))
    else $error("Output does not follow user level");

  // Main scenarios
  accept_c: cover property (@(posedge clk) disable iff (rst) accept);
  gated_c: cover property (@(posedge clk) disable iff (rst)
    hold_lvl && accept);
  overrun_c: cover property (@(posedge clk) disable iff (rst) overrun);
  expose_c: cover property (@(posedge clk) disable iff (rst)
    $fell(expose));
  internal_c: cover property (@(posedge clk) disable iff (rst)
    rate_hit && accept);
endmodule
`default_nettype wire

// file: hdl/itc_pkg.sv
// Constants, register map and enumerations of the capture trigger block.
// Assumes a 125 MHz system clock and a plain strobe register port.
// What this block does
// R1 - Edge, both-edge, gated and burst trigger modes
// R2 - No new trigger while one runs
// R3 - Early trigger dropped, counted as overrun
// R4 - Ready indication can drive switching output
// R5 - Debounce optional, off after reset
// R6 - Debounced pulse must last 4 ms
// R7 - Configurable delay before capture starts
// R8 - One to five capture parameter sets
// R9 - Internal mode captures at fixed rate
// R10 - External capture from pin or command
// R11 - Illumination on for every accepted trigger
// R12 - Lighting leads exposure by 500 us
// R13 - Output inactive and unsourced after defaults
// R14 - Output follows selected device state source
// R15 - Triggers processed only when ready
// R16 - No ready indication in continuous mode
// R17 - Capture finished signalled as own state
// R18 - Internal error shown, details readable
// R19 - Interface control sets output by command
// R20 - Four LEDs enabled independently
// R21 - One colour for all LEDs at once
// R22 - One clock, sync reset, synchronised input
// R23 - Overrun flag sticky until software clears
package itc_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned DEB_MS = 4;
  localparam int unsigned DEB_CYC = (CLK_HZ / 1000) * DEB_MS;
  localparam int unsigned LEAD_US = 500;
  localparam int unsigned LEAD_CYC = (CLK_HZ / 1_000_000) * LEAD_US;
  localparam int unsigned NUM_SETS = 5;
  localparam int unsigned NUM_LEDS = 4;

  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_DELAY   = 4'h1;
  localparam logic [3:0] REG_PERIOD  = 4'h2;
  localparam logic [3:0] REG_SETSEL  = 4'h3;
  localparam logic [3:0] REG_SETVAL  = 4'h4;
  localparam logic [3:0] REG_LIGHT   = 4'h5;
  localparam logic [3:0] REG_OUTCFG  = 4'h6;
  localparam logic [3:0] REG_CMD     = 4'h7;
  localparam logic [3:0] REG_STATUS  = 4'h8;
  localparam logic [3:0] REG_ERRINFO = 4'h9;

  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_INT_BIT  = 3;
  localparam int unsigned CTRL_DEB_BIT  = 4;
  localparam int unsigned CMD_CAP_BIT   = 0;
  localparam int unsigned CMD_LVL_BIT   = 1;
  localparam int unsigned CMD_OVC_BIT   = 2;
  localparam int unsigned CMD_ERC_BIT   = 3;
  localparam int unsigned CMD_USR_BIT   = 4;
  localparam int unsigned CMD_IERR_BIT  = 5;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] DELAY_RST  = 32'h0000_0000;
  localparam logic [31:0] PERIOD_RST = 32'h0001_0000;
  localparam logic [31:0] SETV_RST   = 32'h0000_0064;

  typedef enum logic [2:0] {
    ITC_TM_FALL, ITC_TM_RISE, ITC_TM_BOTH, ITC_TM_GATED, ITC_TM_BURST
  } itc_tmode_t;

  typedef enum logic [2:0] {
    ITC_SRC_NONE, ITC_SRC_READY, ITC_SRC_DONE, ITC_SRC_ERROR,
    ITC_SRC_IFACE, ITC_SRC_USER
  } itc_osrc_t;

  typedef enum {
    ITC_ST_READY, ITC_ST_DELAY, ITC_ST_LEAD, ITC_ST_EXPOSE, ITC_ST_DONE
  } itc_state_t;
endpackage

// file: hdl/itc_sync.sv
// Three-stage synchroniser with agreement filter for the trigger pin.
// Assumes an asynchronous level input.
`timescale 1ns/1ps
`default_nettype none
module itc_sync
  import itc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output var  logic dout
);
  logic s1;
  logic s2;
  logic s3;
  // First stage feeds only the second; level changes on agreement
  always_ff @(posedge clk) begin
    if (rst) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3; // R22
      end
    end
  end
  agree_only_a: assert property (@(posedge clk) disable iff (rst) // R22
    $changed(dout) |-> $past(s2) == dout && $past(s3) == dout)
    else $error("Synchronised level changed without agreement");
endmodule
`default_nettype wire

// file: hdl/itc_debounce.sv
// Optional minimum-width filter for the synchronised trigger level.
// Assumes a synchronised input on the same clock.
`timescale 1ns/1ps
`default_nettype none
module itc_debounce
  import itc_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEB_CYC
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic din,
  output var  logic dout
);
  logic [19:0] cnt;
  wire         differs = (din != dout);
  wire         full    = (cnt >= 20'(DEB_CYCLES - 1));
  // When enabled, both edges need the full width, so short glitches never pass
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt  <= 20'h0_0000;
      dout <= 1'b0;
    end else if (!enable) begin
      cnt  <= 20'h0_0000;
      dout <= din; // R5
    end else if (!differs) begin
      cnt <= 20'h0_0000;
    end else if (full) begin
      cnt  <= 20'h0_0000;
      dout <= din; // R6
    end else begin
      cnt <= cnt + 20'h0_0001;
    end
  end
  accept_width_a: assert property (@(posedge clk) disable iff (rst) // R6
    enable && $past(enable) && $changed(dout) |-> $past(din, 2) == dout)
    else $error("Debounced level changed without held input");
  bypass_off_a: assert property (@(posedge clk) disable iff (rst) // R5
    !enable |=> dout == $past(din))
    else $error("Disabled filter does not pass level through");
endmodule
`default_nettype wire

// file: test/itc_trig_src.sv
// Behavioural trigger sensor driving the camera trigger pin.
// Assumes the bench requests pulses with a one-cycle start strobe.
`timescale 1ns/1ps
`default_nettype none
module itc_trig_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] len,
  output var  logic       trigger_out
);
  logic [7:0] left;

  // Pin rests low between pulses, like an unloaded sensor output
  always_ff @(posedge clk) begin
    if (rst) begin
      left <= 8'h00;
    end else if (start) begin
      left <= len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end

  // Pulse held for the requested width; a new start reloads the count, even mid-pulse
  always_comb trigger_out = (left != 8'h00);
endmodule
`default_nettype wire

// file: test/itc_top_bench.sv
// Self-checking bench for the trigger and illumination sequencer.
// Assumes the sensor model on the pin and short debounce and lead counts.
`timescale 1ns/1ps
`default_nettype none
module itc_top_bench;
  import itc_pkg::*;
  localparam int LEAD = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        start = 1'b0;
  logic        cdone = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [7:0]  len = 8'h00;
  logic [31:0] rdata;
  logic [31:0] d;
  logic        trig;
  logic        sol;
  logic        light_on;
  logic        expose;
  logic [3:0]  led_on;
  logic [1:0]  led_colour;
  logic [2:0]  active_set;
  logic        exp_q = 1'b0;
  logic        saw_out = 1'b0;
  logic [3:0]  seen_led = 4'h0;
  logic [1:0]  seen_col = 2'h0;
  int          errors = 0;
  int          comparisons = 0;
  int          n_exp = 0;
  int          n_ecyc = 0;
  int          n_lcyc = 0;
  int          m;

  itc_trig_src src (.clk(clk), .rst(rst), .start(start), .len(len),
    .trigger_out(trig));
  itc_top #(.DEB_CYCLES(20), .LEAD_CYCLES(LEAD)) dut (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .trigger_in(trig), .capture_done_in(cdone), .switched_output_line(sol),
    .light_on(light_on), .led_on(led_on), .led_colour(led_colour),
    .expose(expose), .active_set(active_set));

  always #4 clk = ~clk;

  // Counts exposures and lit cycles; cleared by the bench between tests
  always @(posedge clk) begin
    exp_q <= expose;
    if (expose && !exp_q) n_exp <= n_exp + 1;
    if (expose) n_ecyc <= n_ecyc + 1;
    if (light_on) begin
      n_lcyc <= n_lcyc + 1;
      seen_led <= led_on;
      seen_col <= led_colour;
    end
    if (sol) saw_out <= 1'b1;
  end

  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [31:0] e);
    logic [31:0] v;
    rreg(a, v);
    chk(nm, e, v);
  endtask

  task automatic clr;
    @(negedge clk);
    n_exp = 0;
    n_ecyc = 0;
    n_lcyc = 0;
    saw_out = 1'b0;
  endtask

  task automatic pulse(input logic [7:0] w);
    @(posedge clk);
    len <= w;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    idle(int'(w) + 80);
  endtask

  // Polls the state field; a capture that never ends closes the run
  task automatic wait_idle;
    logic [31:0] v;
    int i;
    idle(3);
    for (i = 0; i < 60; i++) begin
      rreg(REG_STATUS, v);
      if (v[2:0] === 3'h0) break;
    end
    if (v[2:0] !== 3'h0) begin
      errors++;
      $display("MISMATCH state expected 0 seen %h", v[2:0]);
      stop_test();
    end
  endtask

  initial begin
    idle(100000);
    errors++;
    $display("MISMATCH watchdog expected finish seen hang");
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk("ctrl", REG_CTRL, 32'h0000_0000);
    rchk("delay", REG_DELAY, 32'h0000_0000);
    rchk("period", REG_PERIOD, 32'h0001_0000);
    rchk("outcfg", REG_OUTCFG, 32'h0000_0000);
    rchk("setval", REG_SETVAL, 32'h0000_0064);
    @(negedge clk);
    chk("rd_idle", 32'h0, rdata);
    rchk("unmapped", 4'hF, 32'h0000_0000);
    chk("out_rst", 32'h0, {31'h0, sol});
    $display("test defaults done");
    wreg(REG_DELAY, 32'h0000_0002);
    wreg(REG_SETSEL, 32'h0000_0005);
    rchk("set5", REG_SETVAL, 32'h0000_0000);
    wreg(REG_SETSEL, 32'h0000_0004);
    wreg(REG_SETVAL, 32'h0000_0007);
    wreg(REG_LIGHT, 32'h0000_0025);
    rchk("set4", REG_SETVAL, 32'h0000_0007);
    clr();
    wreg(REG_CMD, 32'h0000_0001);
    wait_idle();
    chk("captures", 32'd1, n_exp);
    chk("expose_len", 32'd7, n_ecyc);
    chk("light_len", LEAD + 7, n_lcyc);
    chk("leds", 32'h5, {28'h0, seen_led});
    chk("colour", 32'h2, {30'h0, seen_col});
    chk("set_used", 32'h4, {29'h0, active_set});
    $display("test command capture done");
    wreg(REG_OUTCFG, 32'h0000_0003);
    clr();
    wreg(REG_CMD, 32'h0000_0001);
    wreg(REG_CMD, 32'h0000_0001);
    wait_idle();
    chk("one_capture", 32'd1, n_exp);
    chk("err_out", 32'h1, {31'h0, saw_out});
    rreg(REG_STATUS, d);
    chk("ovr_err", 32'h3, {30'h0, d[5:4]});
    rchk("ovr_cnt", REG_ERRINFO, 32'h0000_0001);
    rreg(REG_STATUS, d);
    chk("ovr_sticky", 32'h1, {31'h0, d[4]});
    wreg(REG_CMD, 32'h0000_000C);
    rreg(REG_STATUS, d);
    chk("ovr_clr", 32'h0, {30'h0, d[5:4]});
    rchk("cnt_clr", REG_ERRINFO, 32'h0000_0000);
    wreg(REG_CMD, 32'h0000_0020);
    rreg(REG_STATUS, d);
    chk("int_err", 32'h2, {30'h0, d[5:4]});
    wreg(REG_CMD, 32'h0000_0008);
    rreg(REG_STATUS, d);
    chk("err_clr", 32'h0, {31'h0, d[5]});
    $display("test overrun done");
    wreg(REG_OUTCFG, 32'h0000_0001);
    idle(3);
    chk("ready_out", 32'h1, {31'h0, sol});
    wreg(REG_OUTCFG, 32'h0000_0004);
    wreg(REG_CMD, 32'h0000_0002);
    idle(3);
    chk("iface_hi", 32'h1, {31'h0, sol});
    wreg(REG_CMD, 32'h0000_0000);
    idle(3);
    chk("iface_lo", 32'h0, {31'h0, sol});
    wreg(REG_OUTCFG, 32'h0000_0005);
    wreg(REG_CMD, 32'h0000_0010);
    idle(3);
    chk("user_out", 32'h1, {31'h0, sol});
    wreg(REG_OUTCFG, 32'h0000_0002);
    idle(3);
    clr();
    wreg(REG_CMD, 32'h0000_0001);
    wait_idle();
    chk("done_out", 32'h1, {31'h0, saw_out});
    cdone <= 1'b1;
    idle(6);
    rreg(REG_STATUS, d);
    chk("done_in", 32'h1, {31'h0, d[6]});
    $display("test output sources done");
    for (m = 0; m < 5; m++) begin
      wreg(REG_CTRL, 32'(m));
      clr();
      pulse(8'd40);
      if (m < 3) begin
        chk("edge_caps", (m == 2) ? 32'd2 : 32'd1, n_exp);
      end else begin
        chk("level_caps", 32'h1, {31'h0, n_exp >= 2});
      end
    end
    $display("test trigger modes done");
    wreg(REG_CTRL, 32'h0000_0011);
    clr();
    pulse(8'd19);
    chk("short_pulse", 32'd0, n_exp);
    pulse(8'd20);
    chk("long_pulse", 32'd1, n_exp);
    $display("test debounce done");
    wreg(REG_OUTCFG, 32'h0000_0001);
    wreg(REG_PERIOD, 32'h0000_001E);
    wreg(REG_CTRL, 32'h0000_0008);
    idle(5);
    clr();
    idle(300);
    chk("no_ready", 32'h0, {31'h0, saw_out});
    chk("free_run", 32'h1, {31'h0, n_exp >= 5});
    wreg(REG_CTRL, 32'h0000_0000);
    $display("test internal mode done");
    stop_test();
  end
endmodule
`default_nettype wire
